// File: pkg/adc_cfg_pkg.sv
/*
  Register map, field layout and fixed codes of the converter
  configuration bank. Assumes a single 8-bit address space of 16-bit words.
*/
`default_nettype none

package adc_cfg_pkg;

  localparam int NUM_REGS   = 20;
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS  = 16;
  localparam logic [4:0] LAST_BIT = 5'h17;

  // Word indices into the bank
  localparam int IDX_INV   = 0;
  localparam int IDX_PAT   = 1;
  localparam int IDX_CC1   = 2;
  localparam int IDX_CC2   = 3;
  localparam int IDX_CG4   = 4;
  localparam int IDX_CG21  = 5;
  localparam int IDX_JIT   = 6;
  localparam int IDX_CHDIV = 7;
  localparam int IDX_GCFG  = 8;
  localparam int IDX_FG    = 9;
  localparam int NUM_FG    = 4;
  localparam int IDX_XA    = 13;
  localparam int IDX_XB    = 14;
  localparam int IDX_PH    = 15;
  localparam int IDX_TRN   = 16;
  localparam int IDX_FMT   = 17;
  localparam int IDX_BIAS  = 18;
  localparam int IDX_SLP   = 19;

  localparam logic [7:0] SOFT_RESET_ADDR = 8'h00;
  localparam int         SOFT_RESET_BIT  = 0;

  localparam logic [NUM_REGS-1:0][7:0] REG_ADDR = {
    8'h52, 8'h50, 8'h46, 8'h45, 8'h42, 8'h3b, 8'h3a, 8'h37, 8'h36, 8'h35,
    8'h34, 8'h33, 8'h31, 8'h30, 8'h2b, 8'h2a, 8'h27, 8'h26, 8'h25, 8'h24};
  localparam logic [NUM_REGS-1:0][15:0] REG_MASK = {
    16'h0001, 16'h0037, 16'h000c, 16'h0003, 16'h0060, 16'h1f1e, 16'h1f1e,
    16'h7f7f, 16'h7f7f, 16'h7f7f, 16'h7f7f, 16'h0003, 16'h0307, 16'h00ff,
    16'h0fff, 16'hffff, 16'hff00, 16'hff00, 16'h0070, 16'h007f};
  localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020, 16'h0806, 16'h0402,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // Field positions
  localparam int INV4_LSB   = 0;
  localparam int INV2_LSB   = 4;
  localparam int INV1_BIT   = 6;
  localparam int PAT_ONE    = 4;
  localparam int PAT_TWO    = 5;
  localparam int PAT_RAMP   = 6;
  localparam int CODE_LSB   = 8;
  localparam int CG1_LSB    = 8;
  localparam int CG2_LSB    = 0;
  localparam int GAIN_W     = 4;
  localparam int GAIN_MODE  = 0;
  localparam int FINE_EN    = 1;
  localparam int TRIM_W     = 7;
  localparam int TRIM_HI    = 8;
  localparam int CH_LSB     = 0;
  localparam int DIV_LSB    = 8;
  localparam int SEL_W      = 5;
  localparam int SEL_HI     = 8;
  localparam int PH_LSB     = 5;
  localparam int DESKEW_BIT = 0;
  localparam int SYNC_BIT   = 1;
  localparam int TWOS_BIT   = 2;
  localparam int MSB_BIT    = 3;
  localparam int SLEEP_BIT  = 0;

  localparam logic [2:0] CH_ONE  = 3'h1;
  localparam logic [2:0] CH_TWO  = 3'h2;
  localparam logic [1:0] DIV_BY_8 = 2'h3;
  // Cycles between sample ticks minus one, per divide code
  localparam logic [3:0][2:0] DIV_LIMIT = {3'h7, 3'h3, 3'h1, 3'h0};

  localparam logic [7:0] DESKEW_WORD   = 8'haa;
  localparam logic [7:0] SYNC_WORD     = 8'hf0;
  localparam logic       SLEEP_HIGH_Z  = 1'h0;
  localparam logic [6:0] TRIM_ZERO_DB  = 7'h00;

  typedef enum logic [1:0] {MODE_ONE, MODE_TWO, MODE_FOUR} ch_mode_t;

endpackage

`default_nettype wire

// File: hdl/adc_digital_config_registers.sv
/*
  Configuration bank of an interleaved converter: serial write port,
  register words, test pattern and output coding stage.
  Assumes serial pins are synchronous to ref_clk_i and slower than it.
*/
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// (R1) Ramp enable replaces converter data with a repeating full-scale ramp.
// (R2) Two-code enable alternates output between first and second custom code.
// (R3) One-code enable holds the output at the first custom code.
// (R4) First custom code sits in upper byte, resets to zero.
// (R5) Second custom code sits in upper byte, resets to zero.
// (R6) Per-channel swap bits for four, two and one channel modes; default none.
// (R7) Four-channel mode: each channel has own coarse gain nibble, unity default.
// (R8) Two-channel gains in low byte, one-channel gain in bits 11 to 8.
// (R9) Bit 0 of gain word selects coarse gain interpretation, x-gain default.
// (R10) Fine gain applies only while its enable bit 1 is set.
// (R11) Eight 7-bit branch trims, odd branch low, even branch bits 14 to 8.
// (R12) Channel count bits 2 to 0 and divide bits 9 to 8 share one word.
// (R13) Divide field divides input clock by 1, 2, 4 or 8 for sampling.
// (R14) Four 5-bit input selects, LSB zero, converter n defaults to pair n; the mask forces the LSB to zero only for the selects in bits 4 to 0.
// (R15) Bits 6 to 5 set bit clock phase, default 90 degrees.
// (R16) Bit 0 sends deskew pattern, bit 1 sends sync pattern.
// (R17) Bit 1 of training word enables sync pattern, inactive by default.
// (R18) Format bit 2 selects two's complement, else offset binary.
// (R19) Format bit 3 sends MSB first, else LSB first.
// (R20) Bit 0 chooses output behaviour in power down, high-Z default.
// (R21) Host runs a power-down cycle after changing count or divide.
// (R22) Host writes zero into every unused bit.
// (R23) Channel count is one-hot: 001 one, 010 two, 100 four.
// (R24) Divide codes 00, 01, 10, 11 mean divide by 1, 2, 4, 8.
// (R25) Host enables at most one of ramp, one-code and two-code.
// (R26) With no pattern, outputs carry samples in chosen coding and order.
module adc_digital_config_registers
  import adc_cfg_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_sdata_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic [7:0]  sample_i,
  input  wire logic        power_down_i,
  output logic             sample_tick_o,
  output logic [7:0]       lane_word_o,
  output logic [3:0]       swap_inputs_o,
  output logic [15:0]      active_coarse_gain_o,
  output logic             gain_mode_o,
  output logic [55:0]      branch_trim_o,
  output logic [19:0]      converter_input_choice_o,
  output logic [2:0]       channel_count_o,
  output logic [1:0]       clock_divide_o,
  output logic [1:0]       bit_clock_phase_o,
  output logic [7:0]       clock_jitter_adjust_o,
  output logic [15:0]      bias_scaling_o,
  output logic             output_sleep_behaviour_o,
  output logic             lvds_hiz_o
);

  typedef struct packed {
    logic                           sclk_q;
    logic [4:0]                     bits;
    logic [FRAME_BITS-1:0]          shift;
    logic                           full;
    logic [NUM_REGS-1:0][15:0]      regs;
    logic [2:0]                     div;
    logic                           tick;
    logic [7:0]                     ramp;
    logic                           alt;
    logic [7:0]                     word;
    logic [15:0]                    gain;
    logic [3:0]                     swap;
    logic [55:0]                    trim;
    logic                           hiz;
  } state_t;

  localparam state_t ST_RESET = '{regs: REG_RESET, default: '0};

  state_t          st_r;
  state_t          st_nxt;
  logic            wr;
  logic [7:0]      wr_addr;
  logic [15:0]     wr_data;
  logic            tick;
  logic [7:0]      raw;
  logic [7:0]      pat_word;
  logic [15:0]     pat;
  logic [15:0]     fmt;
  logic [15:0]     trn;
  ch_mode_t        mode;

  function automatic logic [7:0] rev8(input logic [7:0] w);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = w[7-i];
    end
    return r;
  endfunction

  // One-hot count to mode; an illegal count behaves as four channels
  function automatic ch_mode_t mode_of(input logic [2:0] cnt);
    ch_mode_t m;
    m = MODE_FOUR;
    if (cnt == CH_ONE) begin
      m = MODE_ONE;
    end else if (cnt == CH_TWO) begin
      m = MODE_TWO;
    end
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt   = st_r;
    wr       = 1'b0;
    pat_word = '0;
    pat      = st_r.regs[IDX_PAT];
    fmt      = st_r.regs[IDX_FMT];
    trn      = st_r.regs[IDX_TRN];
    mode     = mode_of(st_r.regs[IDX_CHDIV][CH_LSB +: 3]);

    // Serial frame: first 24 bits of a select are kept, the rest ignored
    st_nxt.sclk_q = spi_sclk_i;
    if (spi_cs_n_i) begin
      st_nxt.bits = '0;
      st_nxt.full = 1'b0;
    end else if (spi_sclk_i && !st_r.sclk_q && !st_r.full) begin
      st_nxt.shift = {st_r.shift[FRAME_BITS-2:0], spi_sdata_i};
      if (st_r.bits == LAST_BIT) begin
        wr          = 1'b1;
        st_nxt.full = 1'b1;
      end else begin
        st_nxt.bits = st_r.bits + 5'h01;
      end
    end
    wr_addr = st_nxt.shift[FRAME_BITS-1 -: 8];
    wr_data = st_nxt.shift[DATA_BITS-1:0];

    // (R22) Unused bits masked
    if (wr) begin
      if (wr_addr == SOFT_RESET_ADDR && wr_data[SOFT_RESET_BIT]) begin
        st_nxt.regs = REG_RESET;
      end
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_addr == REG_ADDR[i]) begin
          st_nxt.regs[i] = wr_data & REG_MASK[i];
        end
      end
    end

    // (R13) Sampling tick divider
    // (R24) Limit per code
    tick = st_r.div >= DIV_LIMIT[st_r.regs[IDX_CHDIV][DIV_LSB +: 2]];
    st_nxt.div  = tick ? 3'h0 : st_r.div + 3'h1;
    st_nxt.tick = tick;

    // (R18) Output coding
    raw = fmt[TWOS_BIT] ? {~sample_i[7], sample_i[6:0]} : sample_i;
    // (R25) Pattern priority, training first
    if (trn[SYNC_BIT]) begin
      // (R17) Sync pattern
      pat_word = SYNC_WORD;
    end else if (trn[DESKEW_BIT]) begin
      // (R16) Deskew pattern
      pat_word = DESKEW_WORD;
    end else if (pat[PAT_RAMP]) begin
      // (R1) Ramp value
      pat_word = st_r.ramp;
    end else if (pat[PAT_TWO]) begin
      // (R2) Alternating codes
      // (R5) Second code field
      pat_word = st_r.alt ? st_r.regs[IDX_CC2][CODE_LSB +: 8]
                          : st_r.regs[IDX_CC1][CODE_LSB +: 8];
    end else if (pat[PAT_ONE]) begin
      // (R3) Constant code, (R4) from first field
      pat_word = st_r.regs[IDX_CC1][CODE_LSB +: 8];
    end else begin
      // (R26) Converted samples
      pat_word = raw;
    end

    if (tick) begin
      st_nxt.ramp = st_r.ramp + 8'h01;
      st_nxt.alt  = !st_r.alt;
      // (R19) Bit order of lane word
      st_nxt.word = fmt[MSB_BIT] ? pat_word : rev8(pat_word);
    end

    // (R6) Swap per converter
    // (R7) Coarse gain per converter
    // (R8) Two and one channel gains
    // (R23) Mode from one-hot count
    unique case (mode)
      MODE_ONE: begin
        st_nxt.swap = {4{st_r.regs[IDX_INV][INV1_BIT]}};
        st_nxt.gain = {4{st_r.regs[IDX_CG21][CG1_LSB +: GAIN_W]}};
      end
      MODE_TWO: begin
        st_nxt.swap = {{2{st_r.regs[IDX_INV][INV2_LSB+1]}},
                       {2{st_r.regs[IDX_INV][INV2_LSB]}}};
        st_nxt.gain = {{2{st_r.regs[IDX_CG21][CG2_LSB+GAIN_W +: GAIN_W]}},
                       {2{st_r.regs[IDX_CG21][CG2_LSB +: GAIN_W]}}};
      end
      MODE_FOUR: begin
        st_nxt.swap = st_r.regs[IDX_INV][INV4_LSB +: 4];
        st_nxt.gain = st_r.regs[IDX_CG4];
      end
    endcase

    // (R10) Trim gated by enable
    // (R11) Branch pairs per word
    for (int k = 0; k < NUM_FG; k++) begin
      st_nxt.trim[2*TRIM_W*k +: TRIM_W] = TRIM_ZERO_DB;
      st_nxt.trim[2*TRIM_W*k+TRIM_W +: TRIM_W] = TRIM_ZERO_DB;
      if (st_r.regs[IDX_GCFG][FINE_EN]) begin
        st_nxt.trim[2*TRIM_W*k +: TRIM_W] = st_r.regs[IDX_FG+k][0 +: TRIM_W];
        st_nxt.trim[2*TRIM_W*k+TRIM_W +: TRIM_W] = st_r.regs[IDX_FG+k][TRIM_HI +: TRIM_W];
      end
    end

    // (R20) Power-down output behaviour
    st_nxt.hiz = power_down_i && (st_r.regs[IDX_SLP][SLEEP_BIT] == SLEEP_HIGH_Z);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign sample_tick_o        = st_r.tick;
  assign lane_word_o          = st_r.word;
  assign swap_inputs_o        = st_r.swap;
  assign active_coarse_gain_o = st_r.gain;
  assign branch_trim_o        = st_r.trim;
  assign lvds_hiz_o           = st_r.hiz;
  // (R9) Gain interpretation bit
  assign gain_mode_o          = st_r.regs[IDX_GCFG][GAIN_MODE];
  // (R14) Crosspoint selects
  assign converter_input_choice_o = {st_r.regs[IDX_XB][SEL_HI +: SEL_W],
                                     st_r.regs[IDX_XB][0 +: SEL_W],
                                     st_r.regs[IDX_XA][SEL_HI +: SEL_W],
                                     st_r.regs[IDX_XA][0 +: SEL_W]};
  // (R12) Count and divide fields
  assign channel_count_o      = st_r.regs[IDX_CHDIV][CH_LSB +: 3];
  assign clock_divide_o       = st_r.regs[IDX_CHDIV][DIV_LSB +: 2];
  // (R15) Bit clock phase
  assign bit_clock_phase_o    = st_r.regs[IDX_PH][PH_LSB +: 2];
  assign clock_jitter_adjust_o = st_r.regs[IDX_JIT][7:0];
  assign bias_scaling_o       = st_r.regs[IDX_BIAS];
  assign output_sleep_behaviour_o = st_r.regs[IDX_SLP][SLEEP_BIT];

  //////////////////////////////////////////////////////////////////////////

  logic plain;
  assign plain = !trn[SYNC_BIT] && !trn[DESKEW_BIT];
  logic no_pat;
  assign no_pat = !pat[PAT_RAMP] && !pat[PAT_TWO] && !pat[PAT_ONE];

  sequence quiet_seven;
    !st_r.tick [*7];
  endsequence

  sequence div8_tick;
    st_r.tick && clock_divide_o == DIV_BY_8 && !wr;
  endsequence

  ramp_out_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R1)
    st_r.tick && plain && pat[PAT_RAMP] && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == $past(st_r.ramp) && st_r.ramp == $past(st_r.ramp) + 8'h01)
    else $error("ramp word wrong");

  two_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R2)
    st_r.tick && plain && !pat[PAT_RAMP] && pat[PAT_TWO] && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == ($past(st_r.alt) ? st_r.regs[IDX_CC2][CODE_LSB +: 8]
                                        : st_r.regs[IDX_CC1][CODE_LSB +: 8]))
    else $error("two-code word wrong");

  one_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R3)
    st_r.tick && plain && pat[PAT_ONE] && !pat[PAT_TWO] && !pat[PAT_RAMP]
      && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == st_r.regs[IDX_CC1][CODE_LSB +: 8])
    else $error("one-code word wrong");

  code_load_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R4)
    wr && wr_addr == REG_ADDR[IDX_CC1]
      |=> st_r.regs[IDX_CC1] == ($past(wr_data) & REG_MASK[IDX_CC1]))
    else $error("custom code not stored");

  trim_gate_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R10)
    !st_r.regs[IDX_GCFG][FINE_EN] |=> st_r.trim == '0)
    else $error("trim applied while disabled");

  // A divide code other than divide by eight abandons the running attempt
  div_rate_a: assert property (@(posedge ref_clk_i) // (R13)
    disable iff (!arst_n_i || clock_divide_o != DIV_BY_8)
    div8_tick |=> quiet_seven ##1 st_r.tick)
    else $error("divide by eight spacing wrong");

  twos_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R18)
    st_r.tick && plain && no_pat && fmt[TWOS_BIT] && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == {~$past(sample_i[7]), $past(sample_i[6:0])})
    else $error("two's complement coding wrong");

  lsb_order_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R19)
    st_r.tick && plain && no_pat && !fmt[TWOS_BIT] && !fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == rev8($past(sample_i)))
    else $error("lsb-first order wrong");

  sync_word_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R17)
    st_r.tick && trn[SYNC_BIT] && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == SYNC_WORD)
    else $error("sync pattern missing");

  sleep_hiz_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R20)
    power_down_i && !output_sleep_behaviour_o |=> lvds_hiz_o)
    else $error("outputs not high-z in power down");

  second_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R5)
    st_r.tick && plain && !pat[PAT_RAMP] && pat[PAT_TWO] && fmt[MSB_BIT]
      && $stable(st_r.regs) && $past(st_r.alt)
      |-> st_r.word == st_r.regs[IDX_CC2][CODE_LSB +: 8])
    else $error("second custom code wrong");

  swap_four_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R6)
    mode == MODE_FOUR |=> swap_inputs_o == $past(st_r.regs[IDX_INV][INV4_LSB +: 4]))
    else $error("four-channel swap wrong");

  swap_one_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R6)
    mode == MODE_ONE |=> swap_inputs_o == {4{$past(st_r.regs[IDX_INV][INV1_BIT])}})
    else $error("one-channel swap wrong");

  gain_four_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R7)
    mode == MODE_FOUR |=> active_coarse_gain_o == $past(st_r.regs[IDX_CG4]))
    else $error("four-channel gain wrong");

  gain_two_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R8)
    mode == MODE_TWO
      |=> active_coarse_gain_o[GAIN_W-1:0] == $past(st_r.regs[IDX_CG21][CG2_LSB +: GAIN_W]))
    else $error("two-channel gain wrong");

  gain_one_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R8)
    mode == MODE_ONE
      |=> active_coarse_gain_o == {4{$past(st_r.regs[IDX_CG21][CG1_LSB +: GAIN_W])}})
    else $error("one-channel gain wrong");

  trim_pass_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R11)
    st_r.regs[IDX_GCFG][FINE_EN]
      |=> branch_trim_o[TRIM_W +: TRIM_W] == $past(st_r.regs[IDX_FG][TRIM_HI +: TRIM_W]))
    else $error("even branch trim wrong");

  soft_reset_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // Soft reset
    wr && wr_addr == SOFT_RESET_ADDR && wr_data[SOFT_RESET_BIT] |=> st_r.regs == REG_RESET)
    else $error("soft reset left a word changed");

  deskew_word_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R16)
    st_r.tick && !trn[SYNC_BIT] && trn[DESKEW_BIT] && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == DESKEW_WORD)
    else $error("deskew pattern missing");

  div_one_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R24)
    clock_divide_o == '0 |=> st_r.tick)
    else $error("divide by one missed a tick");

  offset_msb_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // (R26)
    st_r.tick && plain && no_pat && !fmt[TWOS_BIT] && fmt[MSB_BIT] && $stable(st_r.regs)
      |-> st_r.word == $past(sample_i))
    else $error("plain sample word wrong");

endmodule // adc_digital_config_registers

`default_nettype wire

// File: testbench/spi_host_model.sv
/*
  Serial host that writes 24-bit configuration frames.
  Assumes the bench calls write_word and that ref_clk_i is free running.
*/
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
  input  wire logic ref_clk_i,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      cs_n_o
);
  initial begin
    sclk_o  = 1'b0;
    sdata_o = 1'b1;
    cs_n_o  = 1'b1;
  end

  task automatic write_word(input logic [7:0] addr, input logic [15:0] data);
    logic [23:0] frame;
    frame = {addr, data};
    @(negedge ref_clk_i) cs_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(negedge ref_clk_i) begin
        sdata_o <= frame[i];
        sclk_o  <= 1'b0;
      end
      @(negedge ref_clk_i);
      @(negedge ref_clk_i) sclk_o <= 1'b1;
      @(negedge ref_clk_i);
    end
    // Idle data line shows no stale bit
    @(negedge ref_clk_i) begin
      sclk_o  <= 1'b0;
      sdata_o <= ~frame[0];
    end
    @(negedge ref_clk_i) cs_n_o <= 1'b1;
  endtask
endmodule // spi_host_model

`default_nettype wire

// File: testbench/adc_digital_config_registers_bench.sv
/*
  Self-checking bench of the configuration bank.
  Assumes spi_host_model drives the serial pins.
*/
`timescale 1ns/1ns
`default_nettype none

module adc_digital_config_registers_bench;
  import adc_cfg_pkg::*;
  logic        ref_clk_i, arst_n_i, sclk, sdata, cs_n, power_down_i, tick, sleep_sel, hiz, gmode;
  logic [7:0]  sample_i, lane, jitter;
  logic [3:0]  swap;
  logic [15:0] cgain, bias;
  logic [55:0] trim;
  logic [19:0] choice;
  logic [2:0]  ch_count;
  logic [1:0]  div, phase;
  int          failures, samples_checked, cycles;

  spi_host_model i_spi_host_model (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .sdata_o(sdata),
    .cs_n_o(cs_n));

  adc_digital_config_registers i_adc_digital_config_registers (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .spi_sclk_i(sclk), .spi_sdata_i(sdata),
    .spi_cs_n_i(cs_n), .sample_i(sample_i), .power_down_i(power_down_i),
    .sample_tick_o(tick), .lane_word_o(lane), .swap_inputs_o(swap),
    .active_coarse_gain_o(cgain), .gain_mode_o(gmode), .branch_trim_o(trim),
    .converter_input_choice_o(choice), .channel_count_o(ch_count), .clock_divide_o(div),
    .bit_clock_phase_o(phase), .clock_jitter_adjust_o(jitter), .bias_scaling_o(bias),
    .output_sleep_behaviour_o(sleep_sel), .lvds_hiz_o(hiz));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_spi_host_model.write_word(a, d);
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic wait_tick();
    @(negedge ref_clk_i);
    for (int i = 0; i < 20 && tick !== 1'b1; i++) @(negedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic reset_values();
    check(ch_count, 3'h4);
    check(div, 2'h0);
    check(choice, {5'h08, 5'h06, 5'h04, 5'h02});
    check(phase, 2'h1);
    check(trim, 56'h0);
    check({gmode, swap, sleep_sel}, 6'h00);
  endtask

  task automatic patterns();
    logic [7:0] a;
    logic [7:0] b;
    wr(8'h46, 16'h0008);
    wr(8'h26, 16'ha500);
    wr(8'h27, 16'h3c00);
    wr(8'h25, 16'h0010);
    wait_tick();
    check(lane, 8'ha5);
    wait_tick();
    check(lane, 8'ha5);
    wr(8'h25, 16'h0020);
    wait_tick();
    a = lane;
    wait_tick();
    b = lane;
    check(a ^ b, 8'h99);
    check(a === 8'ha5 || a === 8'h3c, 1'b1);
    wr(8'h25, 16'h0040);
    wait_tick();
    a = lane;
    wait_tick();
    check(lane, 8'(a + 8'h01));
    wr(8'h45, 16'h0002);
    wait_tick();
    check(lane, 8'hf0);
    wr(8'h45, 16'h0001);
    wait_tick();
    check(lane, 8'haa);
    wr(8'h45, 16'h0000);
    wr(8'h25, 16'h0000);
    sample_i = 8'h12;
    wr(8'h46, 16'h000c);
    wait_tick();
    check(lane, 8'h92);
    wr(8'h46, 16'h0000);
    wait_tick();
    check(lane, 8'h48);
    wait_tick();
    check(lane, 8'h48);
  endtask

  task automatic power_cycle();
    power_down_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    power_down_i = 1'b0;
  endtask

  task automatic divider();
    int n;
    for (int code = 0; code < 4; code++) begin
      wr(8'h31, {6'h00, code[1:0], 8'h04});
      power_cycle();
      check(div, code[1:0]);
      wait_tick();
      n = 0;
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (tick !== 1'b1 && n < 20);
      check(n, 1 << code);
    end
    wr(8'h31, 16'h0004);
  endtask

  task automatic gains();
    wr(8'h2a, 16'h4321);
    check(cgain, 16'h4321);
    check(ch_count, 3'h4);
    wr(8'h24, 16'h000f);
    check(swap, 4'hf);
    wr(8'h34, 16'h2a15);
    check(trim, 56'h0);
    wr(8'h33, 16'h0003);
    check(trim[13:0], {7'h2a, 7'h15});
    check(gmode, 1'b1);
    wr(8'h2b, 16'h0987);
    wr(8'h24, 16'h0050);
    check(swap, 4'h0);
    wr(8'h31, 16'h0002);
    power_cycle();
    check({cgain, swap}, {16'h8877, 4'h3});
    wr(8'h31, 16'h0001);
    power_cycle();
    check({cgain, swap}, {16'h9999, 4'hf});
    wr(8'h31, 16'h0004);
    power_cycle();
    wr(8'h3a, 16'h0c0a);
    check(choice[9:0], {5'h0c, 5'h0a});
    wr(8'h30, 16'h00a5);
    wr(8'h50, 16'h0025);
    check({jitter, bias}, {8'ha5, 16'h0025});
  endtask

  task automatic sleep_and_soft_reset();
    power_down_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check(hiz, 1'b1);
    wr(8'h52, 16'h0001);
    check(hiz, 1'b0);
    power_down_i = 1'b0;
    wr(8'h42, 16'h0060);
    check(phase, 2'h3);
    wr(8'h43, 16'h0000);
    check(phase, 2'h3);
    wr(8'h00, 16'h0001);
    check({phase, sleep_sel}, 3'h2);
    check(trim, 56'h0);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    arst_n_i = 1'b0;
    sample_i = 8'h00;
    power_down_i = 1'b0;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    @(negedge ref_clk_i);
    reset_values();
    patterns();
    divider();
    gains();
    sleep_and_soft_reset();
    summarize();
  end
endmodule // adc_digital_config_registers_bench

`default_nettype wire
